// File: pkg/nand_bus_pkg.sv
package nand_bus_pkg;

  // Wishbone register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIE_RDY = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_ADDR = 8'h10;
  localparam logic [7:0] OFS_CACHE_IDX = 8'h14;
  localparam logic [7:0] OFS_CACHE_DATA = 8'h18;
  localparam logic [7:0] OFS_PTRS = 8'h1C;

  // Field positions
  localparam int CTRL_SYNC_BIT = 0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_ENABLED_BIT = 4;
  localparam int ST_STANDBY_BIT = 5;
  localparam int ST_BUSY_BIT = 6;
  localparam int ST_WP_N_BIT = 7;
  localparam int ST_SYNC_BIT = 8;
  localparam int PTR_OUT_LSB = 16;

  // Reset values
  localparam logic CTRL_SYNC_RST = 1'b0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Timing: figures in ns, counts derived at the core clock rate
  localparam int CORE_CLK_PERIOD_NS = 4;
  localparam int ENABLE_SETTLE_NS = 20;
  localparam int STROBE_FROM_CLOCK_NS = 20;
  // Least time: round up
  localparam int ENABLE_SETTLE_CYC =
    (ENABLE_SETTLE_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  // Longest time: round down, never below one cycle
  localparam int STROBE_DLY_CYC = (STROBE_FROM_CLOCK_NS / CORE_CLK_PERIOD_NS) < 1 ? 1 :
    (STROBE_FROM_CLOCK_NS / CORE_CLK_PERIOD_NS);
  localparam int CNT_W = 8;

  // Synchronised pin vector layout
  localparam int PIN_W = 15;
  localparam int P_DQ_LSB = 0;
  localparam int P_WP_N = 8;
  localparam int P_DQS = 9;
  localparam int P_DIR = 10;
  localparam int P_ALE = 11;
  localparam int P_CLE = 12;
  localparam int P_CE_N = 13;
  localparam int P_CLK = 14;

  // Bus modes of the target
  typedef enum logic [3:0] {
    MODE_STANDBY,
    MODE_DESELECTED,
    MODE_SETTLE,
    MODE_IDLE,
    MODE_DRIVING,
    MODE_CMD_IN,
    MODE_ADDR_IN,
    MODE_DATA_IN,
    MODE_DATA_OUT
  } bus_mode_t;

endpackage

// File: pkg/cache_mem_if.sv
`timescale 1ns/10ps
interface cache_mem_if #(
  parameter int AW = 6,
  parameter int DW = 8
);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: src/cache_mem.sv
`timescale 1ns/10ps
module cache_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input wire logic clk_i,
  cache_mem_if.mem port
);
  import nand_bus_pkg::*;

  typedef struct packed {
    logic [DW-1:0] rdata;
  } mem_state_t;

  logic [DW-1:0] store_r [2**AW];
  mem_state_t st_r;
  mem_state_t st_nxt;

  // Read data leaves through a register
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = store_r[port.raddr];
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
    if (port.we) begin
      store_r[port.waddr] <= port.wdata;
    end
  end

  assign port.rdata = st_r.rdata;
endmodule // cache_mem

// File: src/nand_sync_target.sv
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module nand_sync_target #(
  parameter int NUM_DIES = 2,
  parameter int CACHE_AW = 6
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Per-die ready flags from the die logic
  input wire logic [NUM_DIES-1:0] DIE_RDY_I,
  // Host pins
  input wire logic LINK_CLK_I,
  input wire logic CE_N_I,
  input wire logic CLE_I,
  input wire logic ALE_I,
  input wire logic READ_STROBE_N_I,
  input wire logic WP_N_I,
  input wire logic DQS_I,
  output logic DQS_O,
  output logic DQS_OE_N_O,
  input wire logic [7:0] DQ_I,
  output logic [7:0] DQ_O,
  output logic DQ_OE_N_O,
  output logic RB_O,
  output logic RB_OE_N_O,
  output logic [3:0] MODE_O,
  output logic STANDBY_O
);
  import nand_bus_pkg::*;

  initial begin
    if (NUM_DIES < 1 || NUM_DIES > 16) $error("NUM_DIES out of range");
    if (CACHE_AW < 1 || CACHE_AW > 12) $error("CACHE_AW out of range");
  end

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic clk_prev;
    logic dqs_prev;
    logic sync_en;
    bus_mode_t mode;
    logic [CNT_W-1:0] settle_cnt;
    logic [7:0] cmd;
    logic [7:0] addr;
    logic in_arm;
    logic [CACHE_AW-1:0] in_ptr;
    logic [CACHE_AW-1:0] out_ptr;
    logic [CNT_W-1:0] dly_cnt;
    logic dly_lvl;
    logic [CACHE_AW-1:0] bus_idx;
    logic wb_pend;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic dqs_o;
    logic dqs_oe_n;
    logic [7:0] dq_o;
    logic dq_oe_n;
    logic rb_oe_n;
    logic standby;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;

  cache_mem_if #(.AW(CACHE_AW), .DW(8)) cache ();

  cache_mem #(.AW(CACHE_AW), .DW(8)) u_cache (
    .clk_i(CORE_CLK_I),
    .port(cache.mem)
  );

  logic [PIN_W-1:0] pins;
  logic clk_rise;
  logic clk_edge;
  logic dqs_edge;
  logic busy;
  logic selected;
  logic wb_req;
  logic [31:0] status_word;
  logic [31:0] die_word;
  logic [31:0] ptr_word;

  // Pin vector; the clock is sampled like any other input
  assign pins = {LINK_CLK_I, CE_N_I, CLE_I, ALE_I, READ_STROBE_N_I, DQS_I, WP_N_I, DQ_I};
  assign clk_rise = st_r.sync2[P_CLK] && !st_r.clk_prev;
  assign clk_edge = st_r.sync2[P_CLK] != st_r.clk_prev;
  assign dqs_edge = st_r.sync2[P_DQS] != st_r.dqs_prev;
  assign busy = !(&DIE_RDY_I);
  assign selected = !st_r.sync2[P_CE_N];
  assign wb_req = WB_CYC_I && WB_STB_I && !st_r.wb_pend && !st_r.wb_ack;

  // Read views of block state
  always_comb begin
    status_word = WORD_ZERO;
    status_word[ST_MODE_LSB +: 4] = st_r.mode;
    status_word[ST_ENABLED_BIT] = st_r.mode != MODE_SETTLE && st_r.mode != MODE_DESELECTED &&
      st_r.mode != MODE_STANDBY;
    status_word[ST_STANDBY_BIT] = st_r.standby;
    status_word[ST_BUSY_BIT] = busy;
    status_word[ST_WP_N_BIT] = st_r.sync2[P_WP_N];
    status_word[ST_SYNC_BIT] = st_r.sync_en;
    die_word = WORD_ZERO;
    die_word[NUM_DIES-1:0] = DIE_RDY_I;
    ptr_word = WORD_ZERO;
    ptr_word[CACHE_AW-1:0] = st_r.in_ptr;
    ptr_word[PTR_OUT_LSB +: CACHE_AW] = st_r.out_ptr;
  end

  // Cache ports: link writes, shared read port
  always_comb begin
    cache.we = 1'b0;
    cache.waddr = st_r.in_ptr;
    cache.wdata = st_r.sync2[P_DQ_LSB +: 8];
    cache.raddr = (st_r.mode == MODE_DATA_OUT) ? st_r.out_ptr : st_r.bus_idx;
    if (st_r.sync_en && selected && st_r.in_arm && dqs_edge) begin
      cache.we = 1'b1;
    end
  end

  // Whole next state
  always_comb begin
    st_nxt = st_r;
    // Two flops before any logic looks at a pin
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.clk_prev = st_r.sync2[P_CLK];
    st_nxt.dqs_prev = st_r.sync2[P_DQS];

    // Ready line only ever pulls low; released while all dies ready
    st_nxt.rb_oe_n = !busy;
    st_nxt.standby = !selected && !busy;

    // Selection sequencing; a stopped clock while deselected changes nothing
    if (!st_r.sync_en || !selected) begin
      st_nxt.mode = busy ? MODE_DESELECTED : MODE_STANDBY;
      st_nxt.settle_cnt = CNT_W'(ENABLE_SETTLE_CYC);
      st_nxt.in_arm = 1'b0;
      st_nxt.dly_cnt = '0;
    end else if (st_r.mode == MODE_STANDBY || st_r.mode == MODE_DESELECTED) begin
      st_nxt.mode = MODE_SETTLE;
    end else if (st_r.mode == MODE_SETTLE) begin
      // Bus counts as idle only once the settle time has run out
      if (st_r.settle_cnt <= CNT_W'(1)) begin
        st_nxt.mode = MODE_IDLE;
      end else begin
        st_nxt.settle_cnt = st_r.settle_cnt - CNT_W'(1);
      end
    end else if (clk_rise) begin
      // Mode decode on the rising link clock edge
      unique case ({st_r.sync2[P_CLE], st_r.sync2[P_ALE]})
        2'b00: begin
          st_nxt.mode = st_r.sync2[P_DIR] ? MODE_IDLE : MODE_DRIVING;
        end
        2'b10: begin
          if (st_r.sync2[P_DIR]) begin
            st_nxt.mode = MODE_CMD_IN;
            st_nxt.cmd = st_r.sync2[P_DQ_LSB +: 8];
            st_nxt.in_ptr = '0;
            st_nxt.out_ptr = '0;
            st_nxt.in_arm = 1'b0;
          end else begin
            st_nxt.mode = MODE_DRIVING;
          end
        end
        2'b01: begin
          if (st_r.sync2[P_DIR]) begin
            st_nxt.mode = MODE_ADDR_IN;
            st_nxt.addr = st_r.sync2[P_DQ_LSB +: 8];
            st_nxt.in_arm = 1'b0;
          end else begin
            st_nxt.mode = MODE_DRIVING;
          end
        end
        2'b11: begin
          if (st_r.sync2[P_DIR]) begin
            st_nxt.mode = MODE_DATA_IN;
            st_nxt.in_arm = 1'b1;
          end else begin
            st_nxt.mode = MODE_DATA_OUT;
            st_nxt.in_arm = 1'b0;
          end
        end
      endcase
    end

    // Host strobe edges write bytes; tail bytes after exit still land
    if (cache.we) begin
      st_nxt.in_ptr = st_r.in_ptr + CACHE_AW'(1);
    end
    if (st_nxt.mode == MODE_DRIVING || st_nxt.mode == MODE_DATA_OUT) begin
      st_nxt.in_arm = 1'b0;
    end

    // Output strobe follows each link clock edge after the fixed delay
    // The latching rising edge already launches the first strobe edge
    if (clk_edge && (st_r.mode == MODE_DATA_OUT || st_nxt.mode == MODE_DATA_OUT)) begin
      st_nxt.dly_cnt = CNT_W'(STROBE_DLY_CYC);
      st_nxt.dly_lvl = st_r.sync2[P_CLK];
    end else if (st_r.dly_cnt != '0) begin
      st_nxt.dly_cnt = st_r.dly_cnt - CNT_W'(1);
    end
    if (st_r.dly_cnt == CNT_W'(1)) begin
      st_nxt.dqs_o = st_r.dly_lvl;
      st_nxt.dq_o = cache.rdata;
      st_nxt.out_ptr = st_r.out_ptr + CACHE_AW'(1);
    end

    // Pin ownership from the latched direction
    if (st_nxt.mode == MODE_DRIVING || st_nxt.mode == MODE_DATA_OUT) begin
      st_nxt.dq_oe_n = 1'b0;
      st_nxt.dqs_oe_n = 1'b0;
    end else begin
      st_nxt.dq_oe_n = 1'b1;
      st_nxt.dqs_oe_n = 1'b1;
    end
    if (st_nxt.mode == MODE_DRIVING) begin
      st_nxt.dqs_o = 1'b0;
      st_nxt.dly_cnt = '0;
    end
    if (st_nxt.dq_oe_n) begin
      st_nxt.dqs_o = 1'b0;
    end

    // Wishbone: request taken, answered one cycle later
    st_nxt.wb_ack = 1'b0;
    st_nxt.wb_pend = wb_req;
    if (wb_req && WB_WE_I) begin
      unique case (WB_ADR_I)
        OFS_CTRL: begin
          if (WB_SEL_I[0]) begin
            st_nxt.sync_en = WB_DAT_I[CTRL_SYNC_BIT];
          end
        end
        OFS_CACHE_IDX: begin
          if (WB_SEL_I[0]) begin
            st_nxt.bus_idx = WB_DAT_I[CACHE_AW-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (st_r.wb_pend) begin
      st_nxt.wb_ack = 1'b1;
      st_nxt.wb_dat = WORD_ZERO;
      if (!WB_WE_I) begin
        unique case (WB_ADR_I)
          OFS_CTRL: st_nxt.wb_dat[CTRL_SYNC_BIT] = st_r.sync_en;
          OFS_STATUS: st_nxt.wb_dat = status_word;
          OFS_DIE_RDY: st_nxt.wb_dat = die_word;
          OFS_CMD: st_nxt.wb_dat[7:0] = st_r.cmd;
          OFS_ADDR: st_nxt.wb_dat[7:0] = st_r.addr;
          OFS_CACHE_IDX: st_nxt.wb_dat[CACHE_AW-1:0] = st_r.bus_idx;
          OFS_CACHE_DATA: st_nxt.wb_dat[7:0] = cache.rdata;
          OFS_PTRS: st_nxt.wb_dat = ptr_word;
          default: st_nxt.wb_dat = WORD_ZERO;
        endcase
      end
    end
  end

  // Single state register; synchronous reset
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      st_r <= '0;
      st_r.sync_en <= CTRL_SYNC_RST;
      st_r.mode <= MODE_STANDBY;
      st_r.cmd <= BYTE_RST;
      st_r.addr <= BYTE_RST;
      st_r.dq_o <= BYTE_RST;
      st_r.dqs_oe_n <= 1'b1;
      st_r.dq_oe_n <= 1'b1;
      st_r.rb_oe_n <= 1'b1;
      st_r.clk_prev <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign WB_DAT_O = st_r.wb_dat;
  assign WB_ACK_O = st_r.wb_ack;
  assign DQS_O = st_r.dqs_o;
  assign DQS_OE_N_O = st_r.dqs_oe_n;
  assign DQ_O = st_r.dq_o;
  assign DQ_OE_N_O = st_r.dq_oe_n;
  assign RB_O = 1'b0 & st_r.rb_oe_n; // Open drain: only ever drives low
  assign RB_OE_N_O = st_r.rb_oe_n;
  assign MODE_O = st_r.mode;
  assign STANDBY_O = st_r.standby;

endmodule // nand_sync_target

// File: test/nand_sync_target_assertions.sv
`timescale 1ns/10ps
module nand_sync_target_assertions #(
  parameter int NUM_DIES = 2
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [NUM_DIES-1:0] DIE_RDY_I,
  input wire logic LINK_CLK_I,
  input wire logic CLE_I,
  input wire logic ALE_I,
  input wire logic DQS_O,
  input wire logic DQS_OE_N_O,
  input wire logic DQ_OE_N_O,
  input wire logic [3:0] MODE_O,
  input wire logic RB_OE_N_O,
  input wire logic STANDBY_O
);
  import nand_bus_pkg::*;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  // Pull-down tracks the AND of the die flags one edge later
  property p_rb; !$past(SRST_I) |-> RB_OE_N_O == &$past(DIE_RDY_I); endproperty
  a_rb: assert property (p_rb) else $error("ready line wrong");
  // A target busy for three cycles running never reports standby
  property p_sb; (!(&DIE_RDY_I))[*3] |-> !STANDBY_O; endproperty
  a_sb: assert property (p_sb) else $error("standby while busy");
  property p_drv; MODE_O == MODE_DRIVING |-> !DQS_OE_N_O && !DQ_OE_N_O; endproperty
  a_drv: assert property (p_drv) else $error("driving not driven");
  property p_in; MODE_O inside {MODE_IDLE, MODE_CMD_IN, MODE_ADDR_IN, MODE_DATA_IN}
    |-> DQS_OE_N_O && DQ_OE_N_O; endproperty
  a_in: assert property (p_in) else $error("input mode drives");
  property p_off; MODE_O inside {MODE_STANDBY, MODE_DESELECTED, MODE_SETTLE}
    |-> DQS_OE_N_O && DQ_OE_N_O; endproperty
  a_off: assert property (p_off) else $error("deselected drives");
  // Settle lasts its full count, then the bus is idle
  property p_set; MODE_O == MODE_SETTLE && $past(MODE_O) != MODE_SETTLE
    |-> (MODE_O == MODE_SETTLE)[*4] ##[1:2] MODE_O == MODE_IDLE; endproperty
  a_set: assert property (p_set) else $error("settle wrong");
  property p_dqs; $rose(LINK_CLK_I) && CLE_I && ALE_I && MODE_O == MODE_DATA_OUT |-> ##[6:14] $rose(DQS_O); endproperty
  a_dqs: assert property (p_dqs) else $error("strobe late");
  property p_ack; $rose(WB_STB_I) |-> !WB_ACK_O[*2] ##1 WB_ACK_O ##1 !WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  c_out: cover property (MODE_O == MODE_DATA_OUT);
  c_in: cover property (MODE_O == MODE_DATA_IN);
  c_sb: cover property ($rose(STANDBY_O));
endmodule // nand_sync_target_assertions
bind nand_sync_target nand_sync_target_assertions #(.NUM_DIES(NUM_DIES)) nand_sync_target_assertions_i (.*);

// File: test/nand_host_model.sv
`timescale 1ns/10ps
module nand_host_model #(
  parameter int WAIT_CYC = 2
) (
  output logic link_clk_o,
  output logic ce_n_o,
  output logic cle_o,
  output logic ale_o,
  output logic dir_o,
  output logic dqs_o,
  output logic [7:0] dq_o,
  output logic drv_o
);
  logic run;
  initial begin
    {run, link_clk_o, cle_o, ale_o, dqs_o, drv_o} = 6'h00;
    {ce_n_o, dir_o} = 2'h3;
    dq_o = 8'h00;
  end
  // Clock stands low outside frames
  always #40 link_clk_o <= run ? ~link_clk_o : 1'b0;
  // Pins move after the falling edge; drive only once the target let go
  task automatic beat(input logic c, input logic a, input logic d, input logic [7:0] v);
    @(negedge link_clk_o);
    cle_o <= c;
    ale_o <= a;
    dir_o <= d;
    drv_o <= d & dir_o;
    dq_o <= v;
    @(posedge link_clk_o);
  endtask
  task automatic idle;
    beat(1'b0, 1'b0, 1'b1, 8'h00);
    repeat (WAIT_CYC) @(posedge link_clk_o);
  endtask
  task automatic sel(input logic s);
    run = 1'b1;
    beat(1'b0, 1'b0, 1'b1, 8'h00);
    @(negedge link_clk_o);
    ce_n_o <= !s;
    repeat (WAIT_CYC) @(posedge link_clk_o);
  endtask
  task automatic desel;
    idle();
    @(negedge link_clk_o);
    ce_n_o <= 1'b1;
    @(posedge link_clk_o);
    run = 1'b0;
  endtask
  // Two bytes a clock, each centred on a strobe edge
  task automatic din(input logic [31:0] w);
    beat(1'b1, 1'b1, 1'b1, 8'h00);
    for (int i = 0; i < 4; i += 2) begin
      @(negedge link_clk_o);
      dq_o <= w[8*i +: 8];
      #20 dqs_o <= 1'b1;
      @(posedge link_clk_o);
      dq_o <= w[8*i+8 +: 8];
      #20 dqs_o <= 1'b0;
    end
    idle();
  endtask
  task automatic dout(input int n);
    repeat (WAIT_CYC) @(posedge link_clk_o);
    repeat (n) beat(1'b1, 1'b1, 1'b0, 8'h00);
    beat(1'b0, 1'b0, 1'b0, 8'h00);
    idle();
  endtask
endmodule // nand_host_model

// File: test/tb_nand_sync_target.sv
`timescale 1ns/10ps
module tb_nand_sync_target;
  import nand_bus_pkg::*;
  logic clk, rst, cyc, stb, we, ack, lclk, ce_n, cle, ale, dir;
  logic h_dqs, h_drv, dqs_o, dqs_oe_n, dq_oe_n, rb, rb_oe_n, sb, dqs_q;
  logic [7:0] adr, dq_o, h_dq;
  logic [31:0] wdat, rdat, q;
  logic [1:0] die;
  logic [3:0] mode;
  logic [3:0] sel;
  logic wp_n;
  logic [7:0] outq[$];
  int error_cnt = 0;
  int check_count = 0;
  // Released DQ and DQS show the host value while the host drives, else its inverse; the released ready line reads high
  wire logic dqs_w = !dqs_oe_n ? dqs_o : (h_drv ? h_dqs : ~h_dqs);
  wire logic [7:0] dq_w = !dq_oe_n ? dq_o : (h_drv ? h_dq : ~h_dq);
  wire logic rb_w = rb_oe_n ? 1'b1 : rb;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  nand_sync_target #(.NUM_DIES(2), .CACHE_AW(6)) nand_sync_target_i (
    .CORE_CLK_I(clk),
    .SRST_I(rst),
    .WB_CYC_I(cyc),
    .WB_STB_I(stb),
    .WB_WE_I(we),
    .WB_ADR_I(adr),
    .WB_DAT_I(wdat),
    .WB_SEL_I(sel),
    .WB_DAT_O(rdat),
    .WB_ACK_O(ack),
    .DIE_RDY_I(die),
    .LINK_CLK_I(lclk),
    .CE_N_I(ce_n),
    .CLE_I(cle),
    .ALE_I(ale),
    .READ_STROBE_N_I(dir),
    .WP_N_I(wp_n),
    .DQS_I(dqs_w),
    .DQS_O(dqs_o),
    .DQS_OE_N_O(dqs_oe_n),
    .DQ_I(dq_w),
    .DQ_O(dq_o),
    .DQ_OE_N_O(dq_oe_n),
    .RB_O(rb),
    .RB_OE_N_O(rb_oe_n),
    .MODE_O(mode),
    .STANDBY_O(sb)
  );
  nand_host_model #(.WAIT_CYC(2)) nand_host_model_i (
    .link_clk_o(lclk),
    .ce_n_o(ce_n),
    .cle_o(cle),
    .ale_o(ale),
    .dir_o(dir),
    .dqs_o(h_dqs),
    .dq_o(h_dq),
    .drv_o(h_drv)
  );
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk("ack", 32'h1, 32'(ack));
    q = rdat;
    {cyc, stb} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, WORD_ZERO);
    chk(nm, e, q);
  endtask
  task automatic md(input bus_mode_t m);
    repeat (8) @(posedge clk);
    chk("mode", 32'(m), 32'(mode));
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Bytes taken on strobe changes; two drivers at once is a fault
  always @(posedge clk) begin
    if (dqs_oe_n === 1'b0 && dqs_o !== dqs_q) outq.push_back(dq_o);
    if (dq_oe_n === 1'b0 && h_drv === 1'b1) chk("contention", 32'h0, 32'h1);
    dqs_q = dqs_o;
  end
  // Generous bound on the whole flow
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
  initial begin
    {rst, cyc, stb, we, adr, wdat, die} = {4'h8, 8'h00, WORD_ZERO, 2'h3};
    {sel, wp_n} = 5'h1F;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    md(MODE_STANDBY);
    rd(OFS_CTRL, WORD_ZERO, "ctrl");
    rd(8'h20, WORD_ZERO, "unmapped");
    for (int i = 0; i < 4; i++) begin
      die <= 2'(i);
      repeat (3) @(posedge clk);
      chk("ready line", 32'(i == 3), 32'(rb_w));
      rd(OFS_DIE_RDY, 32'(i), "die flags");
      wb(1'b0, OFS_STATUS, WORD_ZERO);
      chk("busy", 32'(i != 3), 32'(q[ST_BUSY_BIT]));
      chk("standby bit", 32'(i == 3), 32'(q[ST_STANDBY_BIT]));
    end
    // Write protect stays live while deselected
    wp_n <= 1'b0;
    wb(1'b0, OFS_STATUS, WORD_ZERO);
    chk("wp while deselected", 32'h0, 32'(q[ST_WP_N_BIT]));
    wp_n <= 1'b1;
    nand_host_model_i.sel(1'b1);
    nand_host_model_i.beat(1'b1, 1'b0, 1'b1, 8'h5A);
    nand_host_model_i.desel();
    rd(OFS_CMD, WORD_ZERO, "cmd async");
    // Lane 0 off: the enable write must be dropped
    sel <= 4'hE;
    wb(1'b1, OFS_CTRL, 32'h1);
    sel <= 4'hF;
    rd(OFS_CTRL, WORD_ZERO, "lane 0 off");
    wb(1'b1, OFS_CTRL, 32'h1);
    nand_host_model_i.sel(1'b0);
    nand_host_model_i.beat(1'b1, 1'b0, 1'b1, 8'h33);
    nand_host_model_i.desel();
    rd(OFS_CMD, WORD_ZERO, "cmd deselected");
    nand_host_model_i.sel(1'b1);
    md(MODE_IDLE);
    nand_host_model_i.beat(1'b1, 1'b0, 1'b1, 8'hA7);
    md(MODE_CMD_IN);
    nand_host_model_i.idle();
    rd(OFS_CMD, 32'hA7, "command");
    nand_host_model_i.beat(1'b0, 1'b1, 1'b1, 8'h3C);
    md(MODE_ADDR_IN);
    nand_host_model_i.idle();
    rd(OFS_ADDR, 32'h3C, "address");
    nand_host_model_i.din(32'h4433_2211);
    rd(OFS_PTRS, 32'h4, "pointers");
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, OFS_CACHE_IDX, 32'(i));
      rd(OFS_CACHE_DATA, 32'(8'h11 * (i + 1)), "cache");
    end
    nand_host_model_i.beat(1'b0, 1'b0, 1'b0, 8'h00);
    md(MODE_DRIVING);
    chk("strobe low", 32'h0, 32'(dqs_o));
    nand_host_model_i.dout(2);
    chk("bytes out", 32'h4, 32'(outq.size()));
    for (int i = 0; i < 4; i++) chk("data out", 32'(8'h11 * (i + 1)), 32'(outq[i]));
    md(MODE_IDLE);
    chk("released", 32'h1, 32'(dq_oe_n));
    @(posedge clk);
    die <= 2'b10;
    nand_host_model_i.desel();
    md(MODE_DESELECTED);
    chk("standby busy", 32'h0, 32'(sb));
    @(posedge clk);
    die <= 2'b11;
    md(MODE_STANDBY);
    chk("standby", 32'h1, 32'(sb));
    end_sim();
  end
endmodule // tb_nand_sync_target
